// ---- include/dcias_defines.vh ----
// constants for the dual channel integrating converter sequencer
//
// Contract
// - integration length from two-bit field
// - one count per two periods, minus two
// - results saturate at 65535
// - low gain gives one sixteenth counts
// - both channels integrate over same period
// - broadband to first, infrared to second register
// - result transfer is double buffered
// - next integration starts automatically after transfer
// - result bytes at addresses c, d, e, f
`ifndef DCIAS_DEFINES_VH
`define DCIAS_DEFINES_VH

`define DCIAS_CYC_UNIT     19'd918
`define DCIAS_MULT_00      9'd11
`define DCIAS_MULT_01      9'd81
`define DCIAS_MULT_10      9'd322
`define DCIAS_TINT_00      2'h0
`define DCIAS_TINT_01      2'h1
`define DCIAS_TINT_10      2'h2
`define DCIAS_OFFSET       16'd2
`define DCIAS_FULL_SCALE   16'hffff
`define DCIAS_RAW_LIMIT    17'h10001
`define DCIAS_GAIN_DIV_LOG 4
`define DCIAS_ADDR_BB_LO   4'hc
`define DCIAS_ADDR_BB_HI   4'hd
`define DCIAS_ADDR_IR_LO   4'he
`define DCIAS_ADDR_IR_HI   4'hf

`endif

// ---- tb/dcias_properties.sv ----
// port checker for the converter sequencer
`timescale 1ns/1ns
module dcias_chk (
  input wire       I_MCLK,
  input wire       I_RST,
  input wire       I_OSC_EN,
  input wire       I_RD,
  input wire [3:0] I_ADDR,
  input wire [7:0] O_RDATA,
  input wire       O_RVALID,
  input wire       O_DONE
);
  reg [18:0] tick_ff;
  // osc ticks since the last done pulse; bounds are loose for the restart gap
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST)
      tick_ff <= 19'h0;
    else if (O_DONE)
      tick_ff <= 19'h0;
    else if (I_OSC_EN)
      tick_ff <= tick_ff + 19'h1;
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  sequence rd_s;
    I_RD;
  endsequence
  rd_valid_a: assert property (rd_s |=> O_RVALID)
    else $error("no valid after read");
  idle_valid_a: assert property (!I_RD |=> !O_RVALID)
    else $error("valid without read");
  rv_cause_a: assert property (O_RVALID |-> $past(I_RD))
    else $error("valid without cause");
  rdata_hold_a: assert property (!I_RD |=> $stable(O_RDATA))
    else $error("read data moved");
  unmapped_zero_a: assert property (I_RD && I_ADDR < 4'hc |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  done_gap_a: assert property (O_DONE |=> !O_DONE [*8])
    else $error("done not a lone pulse");
  period_min_a: assert property (O_DONE |-> tick_ff >= 19'd10098)
    else $error("period too short");
  period_max_a: assert property (tick_ff <= 19'd295597)
    else $error("period too long");
endmodule
bind dcias_top dcias_chk dcias_chk_i (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_OSC_EN(I_OSC_EN),
  .I_RD(I_RD), .I_ADDR(I_ADDR), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_DONE(O_DONE));

// ---- tb/dcias_top_test.sv ----
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
module dcias_top_test;
  reg        I_MCLK, I_RST, I_RD, I_BB_PULSE, I_IR_PULSE, I_LOW_GAIN;
  reg  [3:0] I_ADDR;
  wire [7:0] O_RDATA;
  wire       O_RVALID, O_DONE;
  integer    error_cnt, n_tests, cyc;
  // osc tick every cycle keeps the shortest period near 10k cycles;
  // the longer field codes would not fit the run budget, so only code 00 runs
  dcias_top dcias_top_i (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_OSC_EN(1'b1), .I_TINT(2'h0),
    .I_LOW_GAIN(I_LOW_GAIN), .I_BB_PULSE(I_BB_PULSE), .I_IR_PULSE(I_IR_PULSE), .I_RD(I_RD),
    .I_ADDR(I_ADDR), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_DONE(O_DONE));
  task close_out;
    begin
      $display("errors %0d tests %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      @(posedge I_MCLK);
      I_RD <= 1'b1;
      I_ADDR <= a;
      @(posedge I_MCLK);
      I_RD <= 1'b0;
      #1;
      chk({7'h0, O_RVALID}, 8'h01);
      chk(O_RDATA, e);
    end
  endtask
  task wait_done;
    begin
      @(posedge I_MCLK);
      #1;
      while (O_DONE !== 1'b1) begin
        @(posedge I_MCLK);
        #1;
      end
    end
  endtask
  // full light on broadband only: 11*918/2-2 = 5047
  task test_full;
    begin
      wait_done;
      rd(4'hc, 8'hb7);
      rd(4'hd, 8'h13);
      rd(4'he, 8'h00);
      rd(4'hf, 8'h00);
      $display("test full done");
    end
  endtask
  // light moved to infrared; a low read before the next transfer freezes the old
  // high byte across it; a second high read, after the freeze drops, sees the mixed period's live 00
  task test_swap;
    begin
      @(posedge I_MCLK);
      I_BB_PULSE <= 1'b0;
      I_IR_PULSE <= 1'b1;
      rd(4'hc, 8'hb7);
      wait_done;
      rd(4'hd, 8'h13);
      rd(4'hd, 8'h00);
      wait_done;
      rd(4'hc, 8'h00);
      rd(4'hd, 8'h00);
      rd(4'he, 8'hb7);
      rd(4'hf, 8'h13);
      rd(4'h3, 8'h00);
      $display("test swap done");
    end
  endtask
  // low gain, both channels lit: 5049 accepted pulses / 16 = 315, less 2 = 313
  task test_gain;
    begin
      @(posedge I_MCLK);
      I_LOW_GAIN <= 1'b1;
      I_BB_PULSE <= 1'b1;
      wait_done;
      wait_done;
      rd(4'hc, 8'h39);
      rd(4'hd, 8'h01);
      rd(4'he, 8'h39);
      rd(4'hf, 8'h01);
      $display("test gain done");
    end
  endtask
  initial begin
    I_MCLK = 1'b0;
    forever #25 I_MCLK = ~I_MCLK;
  end
  // watchdog: five periods of about 10k cycles fit well inside the ceiling
  always @(posedge I_MCLK) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  initial begin
    {error_cnt, n_tests, cyc} = 0;
    {I_RST, I_BB_PULSE, I_IR_PULSE, I_LOW_GAIN, I_RD, I_ADDR} = 9'h180;
    repeat (6) @(posedge I_MCLK);
    I_RST <= 1'b0;
    test_full;
    test_swap;
    test_gain;
    close_out;
  end
endmodule

// ---- verilog/dcias_channel.v ----
// one integrating channel: pulse accumulator with gain prescale
`timescale 1ns/1ns
`include "dcias_defines.vh"

module dcias_channel (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_osc_en,
  input  wire        i_start,
  input  wire        i_low_gain,
  input  wire        i_pulse,
  output wire [15:0] o_count
);

  reg  [16:0] acc_ff;
  reg  [3:0]  pre_ff;
  reg         half_ff;
  wire        tick;
  wire [16:0] net_cnt;

  // at most one pulse per two oscillator periods: half_ff gates alternate periods
  assign tick = i_osc_en & i_pulse & ~half_ff;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_ff  <= 17'h00000;
      pre_ff  <= 4'h0;
      half_ff <= 1'b0;
    end else if (i_start) begin
      acc_ff  <= 17'h00000;
      pre_ff  <= 4'h0;
      half_ff <= 1'b0;
    end else if (i_osc_en) begin
      half_ff <= ~half_ff;
      if (tick) begin
        pre_ff <= pre_ff + 4'h1;
        // raw count stops two above full scale
        if ((!i_low_gain || pre_ff == 4'hf) && acc_ff != `DCIAS_RAW_LIMIT)
          acc_ff <= acc_ff + 17'h00001;
      end
    end
  end

  // offset of two counts
  // the raw limit sits two above full scale, so the result tops out at 65535 with no jump
  assign net_cnt = acc_ff - {1'b0, `DCIAS_OFFSET};
  assign o_count = (acc_ff > {1'b0, `DCIAS_OFFSET}) ? net_cnt[15:0] : 16'h0000;

endmodule

// ---- verilog/dcias_top.v ----
// sequencer for the broadband and infrared integrating channels
`timescale 1ns/1ns
`include "dcias_defines.vh"

module dcias_top (
  input  wire       I_MCLK,
  input  wire       I_RST,
  input  wire       I_OSC_EN,
  input  wire [1:0] I_TINT,
  input  wire       I_LOW_GAIN,
  input  wire       I_BB_PULSE,
  input  wire       I_IR_PULSE,
  input  wire       I_RD,
  input  wire [3:0] I_ADDR,
  output reg  [7:0] O_RDATA,
  output reg        O_RVALID,
  output reg        O_DONE
);

  reg  [18:0] len_ff;
  reg  [18:0] cyc_ff;
  reg         start_ff;
  reg  [15:0] bb_shadow_ff;
  reg  [15:0] ir_shadow_ff;
  reg  [7:0]  hold_ff;
  reg         hold_vld_ff;
  reg         hold_ir_ff;
  reg  [18:0] nxt_len;
  reg  [7:0]  nxt_rdata;
  reg  [7:0]  nxt_hold;
  reg         nxt_hold_vld;
  reg         nxt_hold_ir;
  wire [15:0] bb_count;
  wire [15:0] ir_count;
  wire        period_end;
  wire        last_tick;
  wire        rd_bb_lo;
  wire        rd_ir_lo;

  // length in oscillator cycles for a field code; code 11 is treated as 10
  // the longest length needs 19 bits, so the period registers are that wide
  function [18:0] cyc_len;
    input [1:0] code;
    begin
      case (code)
        `DCIAS_TINT_00: cyc_len = `DCIAS_MULT_00 * `DCIAS_CYC_UNIT;
        `DCIAS_TINT_01: cyc_len = `DCIAS_MULT_01 * `DCIAS_CYC_UNIT;
        default:        cyc_len = `DCIAS_MULT_10 * `DCIAS_CYC_UNIT;
      endcase
    end
  endfunction

  // true when the address is the low byte of the given channel
  function is_low;
    input [3:0] addr;
    input       ir;
    begin
      if (ir)
        is_low = (addr == `DCIAS_ADDR_IR_LO);
      else
        is_low = (addr == `DCIAS_ADDR_BB_LO);
    end
  endfunction

  // high byte as a read sees it: the frozen copy when this channel holds the freeze
  // values come in as arguments so the combinational sensitivity stays complete
  function [7:0] high_byte;
    input [7:0] live;
    input [7:0] held;
    input       frozen;
    begin
      high_byte = frozen ? held : live;
    end
  endfunction

  always @* begin
    nxt_len = cyc_len(I_TINT);
  end

  // last oscillator tick of the period; the restart cycle never ends a period
  assign last_tick  = (cyc_ff == len_ff - 19'd1);
  assign period_end = I_OSC_EN & ~start_ff & last_tick;

  // restart flag: raised by the transfer, dropped by the cycle that reloads
  // auto restart
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      start_ff <= 1'b1;
    end else begin
      start_ff <= period_end;
    end
  end

  // period counter; the field is latched at start so a change mid-period is not torn
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      len_ff <= 19'h00000;
      cyc_ff <= 19'h00000;
    end else if (start_ff) begin
      len_ff <= nxt_len;
      cyc_ff <= 19'h00000;
    end else if (I_OSC_EN && !last_tick) begin
      cyc_ff <= cyc_ff + 19'd1;
    end
  end

  // done pulse rises on the same edge as the transfer and stands for one cycle
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_DONE <= 1'b0;
    end else begin
      O_DONE <= period_end;
    end
  end

  dcias_channel u_bb (
    .i_clk      (I_MCLK),
    .i_rst      (I_RST),
    .i_osc_en   (I_OSC_EN),
    .i_start    (start_ff),
    .i_low_gain (I_LOW_GAIN),
    .i_pulse    (I_BB_PULSE),
    .o_count    (bb_count)
  );

  dcias_channel u_ir (
    .i_clk      (I_MCLK),
    .i_rst      (I_RST),
    .i_osc_en   (I_OSC_EN),
    .i_start    (start_ff),
    .i_low_gain (I_LOW_GAIN),
    .i_pulse    (I_IR_PULSE),
    .o_count    (ir_count)
  );

  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      bb_shadow_ff <= 16'h0000;
      ir_shadow_ff <= 16'h0000;
    end else if (period_end) begin
      bb_shadow_ff <= bb_count;
      ir_shadow_ff <= ir_count;
    end
  end

  // low byte reads, one per channel
  assign rd_bb_lo = I_RD & is_low(I_ADDR, 1'b0);
  assign rd_ir_lo = I_RD & is_low(I_ADDR, 1'b1);

  always @* begin
    case (I_ADDR)
      `DCIAS_ADDR_BB_LO: nxt_rdata = bb_shadow_ff[7:0];
      `DCIAS_ADDR_BB_HI: nxt_rdata = high_byte(bb_shadow_ff[15:8], hold_ff,
                                               hold_vld_ff & ~hold_ir_ff);
      `DCIAS_ADDR_IR_LO: nxt_rdata = ir_shadow_ff[7:0];
      `DCIAS_ADDR_IR_HI: nxt_rdata = high_byte(ir_shadow_ff[15:8], hold_ff,
                                               hold_vld_ff & hold_ir_ff);
      default:           nxt_rdata = 8'h00;
    endcase
  end

  // high byte held from low read
  // reading a low byte freezes that channel's high byte, so a transfer between the
  // two reads cannot mix old and new halves; the freeze remembers its channel so a
  // read of the other channel's high byte is never served the wrong byte
  always @* begin
    nxt_hold     = hold_ff;
    nxt_hold_vld = hold_vld_ff;
    nxt_hold_ir  = hold_ir_ff;
    if (rd_bb_lo) begin
      nxt_hold     = bb_shadow_ff[15:8];
      nxt_hold_vld = 1'b1;
      nxt_hold_ir  = 1'b0;
    end else if (rd_ir_lo) begin
      nxt_hold     = ir_shadow_ff[15:8];
      nxt_hold_vld = 1'b1;
      nxt_hold_ir  = 1'b1;
    end else if (I_RD) begin
      nxt_hold_vld = 1'b0; // any other read drops the freeze
    end
  end

  // freeze registers
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      hold_ff     <= 8'h00;
      hold_vld_ff <= 1'b0;
      hold_ir_ff  <= 1'b0;
    end else begin
      hold_ff     <= nxt_hold;
      hold_vld_ff <= nxt_hold_vld;
      hold_ir_ff  <= nxt_hold_ir;
    end
  end

  // read data stands until the next read; valid echoes the strobe for one cycle
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA  <= 8'h00;
      O_RVALID <= 1'b0;
    end else begin
      O_RVALID <= I_RD;
      if (I_RD) begin
        O_RDATA <= nxt_rdata;
      end
    end
  end

endmodule
